/* File: hdl/scratch_ram.sv */
// Scratch-pad byte memory with registered read data
module scratch_ram (
    input  wire logic       sys_clk_i,
    input  wire logic       ce_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [xfer_pkg::SP_DEPTH];

    // Read first, a write returns the old byte; no reset so it maps to block RAM
    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[addr_i] <= wdata_i;
            end
            rdata_o <= mem[addr_i];
        end
    end

endmodule : scratch_ram

/* File: hdl/xfer_pkg.sv */
// Shared constants and carrier types for the port and scratch-pad unit
package xfer_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int         INSN_W       = 18;
    localparam int         GRP_HI       = 17;
    localparam int         GRP_LO       = 13;
    localparam int         DST_HI       = 12;
    localparam int         DST_LO       = 8;
    localparam int         SRC_HI       = 7;
    localparam int         SRC_LO       = 3;
    localparam int         OP_HI        = 2;
    localparam int         OP_LO        = 0;
    localparam logic [4:0] GRP_XFER     = 5'h1E;

    // Operation codes
    localparam logic [2:0] OP_PORT_WR     = 3'h0;
    localparam logic [2:0] OP_PORT_RD     = 3'h1;
    localparam logic [2:0] OP_PORT_WR_IND = 3'h2;
    localparam logic [2:0] OP_PORT_RD_IND = 3'h3;
    localparam logic [2:0] OP_SP_ST       = 3'h4;
    localparam logic [2:0] OP_SP_LD       = 3'h5;
    localparam logic [2:0] OP_SP_ST_IND   = 3'h6;
    localparam logic [2:0] OP_SP_LD_IND   = 3'h7;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int         SP_DEPTH     = 256;
    localparam int         REGS         = 32;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [4:0] IDX_RST      = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_WBACK = 2'b11
    } state_type;

    // Port bus request toward peripheral logic
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } port_req_type;

    // Register-file write-back request
    typedef struct packed {
        logic       we;
        logic [4:0] idx;
        logic [7:0] data;
    } wback_type;

endpackage : xfer_pkg

/* File: hdl/xfer_unit.sv */
// Port and scratch-pad transfer execution unit
module xfer_unit (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    input  wire logic                    issue_i,
    input  wire logic [17:0]             insn_i,
    input  wire logic [7:0]              dst_val_i,
    input  wire logic [7:0]              base_val_i,
    input  wire logic [7:0]              port_rdata_i,
    output xfer_pkg::port_req_type       port_o,
    output xfer_pkg::wback_type          wback_o,
    output logic                         busy_o,
    output logic                         done_o,
    output logic                         flags_we_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    // Two stages so release is clean against sys_clk_i
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       is_xfer;
    logic [2:0] op;
    logic [4:0] dst_idx;
    logic [4:0] cst;
    logic [7:0] tgt_addr;

    // Bit 1 of the operation picks base register over the constant
    always_comb begin
        is_xfer  = insn_i[xfer_pkg::GRP_HI:xfer_pkg::GRP_LO]
                   == xfer_pkg::GRP_XFER;
        op       = insn_i[xfer_pkg::OP_HI:xfer_pkg::OP_LO];
        dst_idx  = insn_i[xfer_pkg::DST_HI:xfer_pkg::DST_LO];
        cst      = insn_i[xfer_pkg::SRC_HI:xfer_pkg::SRC_LO];
        tgt_addr = op[1] ? base_val_i : {3'h0, cst};
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    xfer_pkg::state_type    state;
    xfer_pkg::state_type    next_state;
    logic [2:0]             op_q;
    logic [2:0]             next_op_q;
    logic [4:0]             idx_q;
    logic [4:0]             next_idx_q;
    xfer_pkg::port_req_type next_port;
    xfer_pkg::wback_type    next_wback;
    logic                   next_done;
    logic                   sp_we;
    logic [7:0]             sp_rdata;
    logic                   start;

    assign start = issue_i && is_xfer;

    // Port strobes last one enabled cycle; loads write back two enabled cycles after the strobe
    always_comb begin
        next_state = state;
        next_op_q  = op_q;
        next_idx_q = idx_q;
        next_port  = '0;
        next_wback = '0;
        next_done  = 1'b0;
        sp_we      = 1'b0;
        case (state)
            xfer_pkg::ST_IDLE: begin
                if (start) begin
                    next_op_q      = op;
                    next_idx_q     = dst_idx;
                    next_port.addr = tgt_addr;
                    next_port.data = dst_val_i;
                    case (op)
                        xfer_pkg::OP_PORT_WR,
                        xfer_pkg::OP_PORT_WR_IND: begin
                            next_port.wr = 1'b1;
                        end
                        xfer_pkg::OP_PORT_RD,
                        xfer_pkg::OP_PORT_RD_IND: begin
                            next_port.rd = 1'b1;
                        end
                        xfer_pkg::OP_SP_ST,
                        xfer_pkg::OP_SP_ST_IND: begin
                            sp_we = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                    next_state = xfer_pkg::ST_EXEC;
                end
            end
            xfer_pkg::ST_EXEC: begin
                next_state = xfer_pkg::ST_WBACK;
            end
            xfer_pkg::ST_WBACK: begin
                next_idx_q = idx_q;
                if (!op_q[2]) begin
                    next_wback.we   = op_q[0];
                    next_wback.data = port_rdata_i;
                end else begin
                    next_wback.we   = op_q[0];
                    next_wback.data = sp_rdata;
                end
                next_wback.idx = idx_q;
                next_done      = 1'b1;
                next_state     = xfer_pkg::ST_IDLE;
            end
            default: begin
                next_state = xfer_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state   <= xfer_pkg::ST_IDLE;
            op_q    <= 3'h0;
            idx_q   <= xfer_pkg::IDX_RST;
            port_o  <= '0;
            wback_o <= '0;
            done_o  <= 1'b0;
            busy_o  <= 1'b0;
        end else if (ce_i) begin
            state   <= next_state;
            op_q    <= next_op_q;
            idx_q   <= next_idx_q;
            port_o  <= next_port;
            wback_o <= next_wback;
            done_o  <= next_done;
            busy_o  <= next_state != xfer_pkg::ST_IDLE;
        end
    end

    // Carry and zero never change for this group
    always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_we_o <= 1'b0;
        end else begin
            flags_we_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Scratch-pad memory
    // ------------------------------------------------------------
    logic sp_ce;

    // Access only when a transfer is taken, so the read data hold
    assign sp_ce = ce_i && state == xfer_pkg::ST_IDLE && start;

    scratch_ram u_sp (
        .sys_clk_i (sys_clk_i),
        .ce_i      (sp_ce),
        .we_i      (sp_we),
        .addr_i    (tgt_addr),
        .wdata_i   (dst_val_i),
        .rdata_o   (sp_rdata)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_take_wr;
        start && !op[2] && !op[0] && state == xfer_pkg::ST_IDLE && ce_i;
    endsequence

    chk_port_wr_strobe: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        s_take_wr |=> port_o.wr && !port_o.rd
    ) else $error("port write strobe missing");

    chk_port_wr_data: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        s_take_wr |=> port_o.data == $past(dst_val_i)
    ) else $error("port write data wrong");

    chk_direct_addr: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (start && !op[1] && state == xfer_pkg::ST_IDLE && ce_i)
        |=> port_o.addr == {3'h0, $past(cst)}
    ) else $error("direct address above 31");

    chk_indirect_addr: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (start && op[1] && state == xfer_pkg::ST_IDLE && ce_i)
        |=> port_o.addr == $past(base_val_i)
    ) else $error("indirect address wrong");

    chk_load_wback: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (start && op[0] && state == xfer_pkg::ST_IDLE && ce_i)
        ##1 ce_i [*2] |=> wback_o.we && done_o
    ) else $error("load did not write back");

    chk_store_no_wb: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (start && !op[0] && state == xfer_pkg::ST_IDLE && ce_i)
        ##1 ce_i [*2] |=> !wback_o.we && done_o
    ) else $error("store wrote a register");

    chk_strobe_pulse: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (port_o.wr || port_o.rd) && ce_i |=> !port_o.wr && !port_o.rd
    ) else $error("port strobe longer than one cycle");

    // Load taken with the enable high in the take cycle
    sequence s_take_ld;
        start && op[0] && state == xfer_pkg::ST_IDLE && ce_i;
    endsequence

    chk_wback_idx: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        s_take_ld ##1 ce_i [*2] |=> wback_o.idx == $past(dst_idx, 3)
    ) else $error("write-back register index wrong");

    chk_flags_kept: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        done_o |-> !flags_we_o
    ) else $error("flags touched by transfer");

    chk_non_group: assert property (
        @(posedge sys_clk_i) disable iff (!rst_sync_n)
        (issue_i && !is_xfer && state == xfer_pkg::ST_IDLE)
        |=> !port_o.wr && !port_o.rd && !busy_o
    ) else $error("foreign opcode acted on");

endmodule : xfer_unit

/* File: tb/port_periph.sv */
// Behavioural peripheral answering the 256-port bus
module port_periph (
    input  wire logic                   sys_clk_i,
    input  wire xfer_pkg::port_req_type port_i,
    output logic [7:0]                  port_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Port contents and read hold
    // ------------------------------------------------------------
    logic [7:0] regs [256];
    int         hold;

    // Known start pattern so every port can be read before written
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i * 7 + 3);
        end
        port_rdata_o = 8'h00;
        hold         = 0;
    end

    // Read byte held two cycles, then toggled so stale data shows
    always @(posedge sys_clk_i) begin
        if (port_i.wr === 1'b1) begin
            regs[port_i.addr] <= port_i.data;
        end
        if (port_i.rd === 1'b1) begin
            port_rdata_o <= regs[port_i.addr];
            hold         <= 2;
        end else if (hold > 1) begin
            hold <= hold - 1;
        end else begin
            hold         <= 0;
            port_rdata_o <= ~port_rdata_o;
        end
    end
endmodule : port_periph

/* File: tb/test_port_scratchpad_load_store.sv */
// Self-checking bench for the port and scratch-pad transfer unit
module test_port_scratchpad_load_store;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and reference model
    // ------------------------------------------------------------
    logic                   sys_clk = 1'b0;
    logic                   rst_n   = 1'b0;
    logic                   ce      = 1'b1;
    logic                   issue   = 1'b0;
    logic [17:0]            insn    = 18'h0_0000;
    logic [7:0]             dst_val = 8'h00;
    logic [7:0]             base_val = 8'h00;
    logic [7:0]             port_rdata;
    xfer_pkg::port_req_type port_o;
    xfer_pkg::wback_type    wback_o;
    logic                   busy_o;
    logic                   done_o;
    logic                   flags_we_o;
    int                     n_mismatch = 0;
    int                     tests_run  = 0;
    logic [7:0]             pm [256];
    logic [7:0]             sm [256];

    always #12.5 sys_clk = ~sys_clk;

    xfer_unit dut (
        .sys_clk_i    (sys_clk),
        .rst_n_i      (rst_n),
        .ce_i         (ce),
        .issue_i      (issue),
        .insn_i       (insn),
        .dst_val_i    (dst_val),
        .base_val_i   (base_val),
        .port_rdata_i (port_rdata),
        .port_o       (port_o),
        .wback_o      (wback_o),
        .busy_o       (busy_o),
        .done_o       (done_o),
        .flags_we_o   (flags_we_o)
    );

    port_periph periph (
        .sys_clk_i    (sys_clk),
        .port_i       (port_o),
        .port_rdata_o (port_rdata)
    );

    // ------------------------------------------------------------
    // Checking and transfer tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One issue, two when hold is set on a group opcode, then six cycles watched for strobe and completion
    task automatic xfer(input logic [4:0] grp, input logic [2:0] op,
                        input logic [4:0] dst, input logic [4:0] src,
                        input logic [7:0] dv, input logic [7:0] bv,
                        input bit hold);
        logic [7:0] a;
        bit         ok;
        int         ns;
        int         nd;
        bit         stall;
        ok = (grp == xfer_pkg::GRP_XFER);
        a  = op[1] ? bv : {3'h0, src};
        ns = 0;
        nd = 0;
        stall = ($urandom % 5 == 0);
        @(posedge sys_clk);
        issue    <= 1'b1;
        insn     <= {grp, dst, src, op};
        dst_val  <= dv;
        base_val <= bv;
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            // Second issue during busy must be ignored
            if (k == 0 && hold && ok) insn <= {xfer_pkg::GRP_XFER, 13'h1_FF8};
            else issue <= 1'b0;
            // One frozen cycle after the take stretches the execute stage and its strobe
            ce <= !(k == 0 && stall);
            @(negedge sys_clk);
            chk(18'(flags_we_o), 18'h0_0000);
            chk(18'(busy_o), 18'(ok && k < (stall ? 3 : 2)));
            if ((port_o.rd | port_o.wr) === 1'b1) begin
                ns++;
                chk(18'({port_o.rd, port_o.wr, port_o.addr}),
                    18'({op[0], ~op[0], a}));
                if (!op[0]) chk(18'(port_o.data), 18'(dv));
            end
            if (done_o === 1'b1) begin
                nd++;
                chk(18'(wback_o.we), 18'(op[0]));
                if (op[0]) chk(18'({wback_o.idx, wback_o.data}),
                    18'({dst, op[2] ? sm[a] : pm[a]}));
            end
        end
        chk(18'(ns), 18'((ok && !op[2]) ? (stall ? 2 : 1) : 0));
        chk(18'(nd), 18'(ok));
        if (ok && !op[0]) begin
            if (op[2]) sm[a] = dv;
            else pm[a] = dv;
        end
    endtask : xfer

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h79e7));
        for (int i = 0; i < 256; i++) begin
            pm[i] = 8'(i * 7 + 3);
        end
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // Fill scratch first: its contents are undefined at reset
        for (int i = 0; i < 256; i++) begin
            xfer(xfer_pkg::GRP_XFER, xfer_pkg::OP_SP_ST_IND, 5'h00, 5'h01,
                 8'($urandom), 8'(i), 1'b0);
        end
        // Every operation at the field boundaries
        for (int k = 0; k < 16; k++) begin
            xfer(xfer_pkg::GRP_XFER, 3'(k), 5'h1F, (k < 8) ? 5'h1F : 5'h00,
                 8'($urandom), (k < 8) ? 8'hFF : 8'h00, 1'b0);
        end
        // Random mix with busy issues and foreign opcodes
        for (int i = 0; i < 300; i++) begin
            xfer(($urandom % 8 == 0) ? 5'h0F : xfer_pkg::GRP_XFER,
                 3'($urandom), 5'($urandom), 5'($urandom), 8'($urandom),
                 8'($urandom), ($urandom % 6 == 0));
        end
        wrap_up();
    end

    // Cuts a hang well beyond the expected four thousand cycles
    initial begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
endmodule : test_port_scratchpad_load_store
